// ==== hw/pmrc_pin_filter.sv ====
// synchronises reset and fetch-select pins and times the reset hold
`timescale 1ns/1ps
module pmrc_pin_filter
    import pmrc_pkg::*;
#(
    parameter int HOLD = PMRC_RST_HOLD_OSC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rst_pin,
    input wire logic ext_fetch_sel_n_pin,
    pmrc_pin_if.filt pins
);

    // ==================================================================
    // three-stage synchronisers, one per pin
    logic [1:0] raw;
    logic [1:0] s1_r, s2_r, s3_r, lvl_r;
    logic [1:0] lvl_nxt;
    assign raw = {ext_fetch_sel_n_pin, rst_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            // a change counts only once stages two and three agree
            always_comb begin
                lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
            end
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    lvl_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    lvl_r[g] <= lvl_nxt[g];
                end
            end
        end
    endgenerate

    // ==================================================================
    // hold timer: counts only while the oscillator runs
    logic [5:0] cnt_r, cnt_nxt;
    logic act_r, act_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        if (!lvl_r[0]) begin
            cnt_nxt = '0;
            act_nxt = 1'b0;
        end else if (pins.osc_run) begin
            if (cnt_r < 6'(HOLD - 1)) begin
                cnt_nxt = cnt_r + 6'd1;
            end else begin
                act_nxt = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            act_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
        end
    end

    assign pins.rst_level = lvl_r[0];
    assign pins.rst_active = act_r;
    assign pins.fetch_level = lvl_r[1];

endmodule // pmrc_pin_filter

// ==== hw/pmrc_pin_if.sv ====
// carrier between the pin filter and the mode controller
`timescale 1ns/1ps
interface pmrc_pin_if;
    logic osc_run;
    logic rst_level;
    logic rst_active;
    logic fetch_level;
    modport filt (
        input osc_run,
        output rst_level,
        output rst_active,
        output fetch_level
    );
    modport core (
        output osc_run,
        input rst_level,
        input rst_active,
        input fetch_level
    );
endinterface

// ==== hw/pmrc_pkg.sv ====
// constants and types shared by the power mode and reset control block
package pmrc_pkg;

    // ==================================================================
    // register map (indices; byte address is four times the index)
    localparam logic [7:0] PMRC_PWR_CTRL_IDX = 8'h87;
    localparam logic [7:0] PMRC_STATUS_IDX = 8'h88;
    localparam int PMRC_ADDR_W = 10;
    localparam logic [9:0] PMRC_PWR_CTRL_ADDR = {PMRC_PWR_CTRL_IDX, 2'b00};
    localparam logic [9:0] PMRC_STATUS_ADDR = {PMRC_STATUS_IDX, 2'b00};

    // ==================================================================
    // power control register fields
    localparam int PMRC_BIT_BAUD = 7;
    localparam int PMRC_BIT_QUIET = 5;
    localparam int PMRC_BIT_GF_HI = 3;
    localparam int PMRC_BIT_GF_LO = 2;
    localparam int PMRC_BIT_PD = 1;
    localparam int PMRC_BIT_IDLE = 0;
    localparam logic [7:0] PMRC_PWR_CTRL_WMASK = 8'haf;
    localparam logic [7:0] PMRC_PWR_CTRL_RESET = 8'h00;

    // status register fields
    localparam int PMRC_ST_IDLE = 0;
    localparam int PMRC_ST_PDOWN = 1;
    localparam int PMRC_ST_EXT = 2;
    localparam int PMRC_ST_RESET = 3;

    // ==================================================================
    // timing, in oscillator periods (one ref_clk cycle each)
    localparam int PMRC_RST_HOLD_OSC = 24;
    localparam int PMRC_ALE_PERIOD_OSC = 6;
    localparam int PMRC_ALE_HIGH_OSC = 2;

    // ==================================================================
    // operating modes
    typedef enum logic [1:0] {
        PMRC_MODE_RUN = 2'b00,
        PMRC_MODE_IDLE = 2'b01,
        PMRC_MODE_PDOWN = 2'b10,
        PMRC_MODE_RESET = 2'b11
    } pmrc_mode_t;

endpackage

// ==== hw/pmrc_top.sv ====
// power mode and reset control with its register slave
// ==================================================================
// Summary of operation
// - reset takes hold only after the reset pin stays high 24 oscillator periods while running.
// - the fetch select pin is latched during reset and ignored afterwards.
// - the internal clock phase is the oscillator divided by two.
// - in idle the processor halts while peripherals and all state are kept.
// - the write that requests idle is the last one acted on before idle begins.
// - idle ends on an enabled interrupt or on a hardware reset.
// - a power-down request stops the oscillator after the requesting write.
// - only a hardware reset leaves power-down; interrupts do not.
// - the power control register sits at index 87h and resets to zero.
// - the register holds baud doubler, strobe quiet, two flags, power-down and idle.
// - reserved bits should not be written with ones and read back as zero here.
// - strobes and ports take fixed states in idle and power-down.
// - strobe quiet stops periodic address strobes and holds the pin low.
// - the strobe still pulses for data moves, high fetches and external fetch.
`timescale 1ns/1ps
module pmrc_top
    import pmrc_pkg::*;
#(
    parameter int HOLD = PMRC_RST_HOLD_OSC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [PMRC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rst_pin,
    input wire logic ext_fetch_sel_n_pin,
    input wire logic irq_pending,
    input wire logic external_data_move,
    input wire logic fetch_above_internal,
    input wire logic cpu_program_fetch_strobe_n,
    output logic cpu_reset,
    output logic cpu_halt,
    output logic osc_run,
    output logic clk_phase_en,
    output logic ale,
    output logic program_fetch_strobe_n,
    output logic port0_float,
    output logic port2_addr_sel,
    output logic ext_fetch,
    output logic baud_doubler
);

    // ==================================================================
    // pin filter
    pmrc_pin_if pins ();
    pmrc_pin_filter #(.HOLD(HOLD)) u_filter (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rst_pin(rst_pin),
        .ext_fetch_sel_n_pin(ext_fetch_sel_n_pin),
        .pins(pins)
    );

    // ==================================================================
    // register slave: one wait cycle, then the answer
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic acc_rd, acc_wr, hit_pwr, hit_st;
    logic [7:0] pwr_r, pwr_nxt, status_w;
    pmrc_mode_t mode_r, mode_nxt;
    logic ext_r, ext_nxt;

    assign hit_pwr = (avs_address == PMRC_PWR_CTRL_ADDR);
    assign hit_st = (avs_address == PMRC_STATUS_ADDR);
    assign acc_wr = avs_write && !wait_r;
    assign acc_rd = avs_read && !wait_r;

    always_comb begin
        status_w = '0;
        status_w[PMRC_ST_IDLE] = (mode_r == PMRC_MODE_IDLE);
        status_w[PMRC_ST_PDOWN] = (mode_r == PMRC_MODE_PDOWN);
        status_w[PMRC_ST_EXT] = ext_r;
        status_w[PMRC_ST_RESET] = (mode_r == PMRC_MODE_RESET);
    end

    // unmapped reads answer zero, unmapped writes are dropped
    always_comb begin
        wait_nxt = !((avs_read || avs_write) && wait_r);
        rdata_nxt = rdata_r;
        if (avs_read && wait_r) begin
            rdata_nxt = '0;
            if (hit_pwr) begin
                rdata_nxt[7:0] = pwr_r & PMRC_PWR_CTRL_WMASK;
            end else if (hit_st) begin
                rdata_nxt[7:0] = status_w;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==================================================================
    // power control register and mode machine
    logic pwr_wr;
    logic [7:0] wbyte;
    assign pwr_wr = acc_wr && hit_pwr && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0] & PMRC_PWR_CTRL_WMASK;

    always_comb begin
        pwr_nxt = pwr_r;
        mode_nxt = mode_r;
        ext_nxt = ext_r;
        if (pins.rst_active) begin
            // internal reset wins over everything
            mode_nxt = PMRC_MODE_RESET;
            pwr_nxt = PMRC_PWR_CTRL_RESET;
            ext_nxt = !pins.fetch_level;
        end else begin
            unique case (mode_r)
                PMRC_MODE_RESET: begin
                    mode_nxt = PMRC_MODE_RUN;
                end
                PMRC_MODE_RUN: begin
                    if (pwr_wr) begin
                        pwr_nxt = wbyte;
                        if (wbyte[PMRC_BIT_PD]) begin
                            mode_nxt = PMRC_MODE_PDOWN;
                        end else if (wbyte[PMRC_BIT_IDLE]) begin
                            mode_nxt = PMRC_MODE_IDLE;
                        end
                    end
                end
                PMRC_MODE_IDLE: begin
                    if (irq_pending) begin
                        mode_nxt = PMRC_MODE_RUN;
                        pwr_nxt[PMRC_BIT_IDLE] = 1'b0;
                    end
                end
                PMRC_MODE_PDOWN: begin
                    mode_nxt = PMRC_MODE_PDOWN;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pwr_r <= PMRC_PWR_CTRL_RESET;
            mode_r <= PMRC_MODE_RESET;
            ext_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            mode_r <= mode_nxt;
            ext_r <= ext_nxt;
        end
    end

    // ==================================================================
    // oscillator gate, divide-by-two phase and strobe timing
    logic osc_r, osc_nxt, phase_r, phase_nxt;
    logic [2:0] alec_r, alec_nxt;
    logic quiet_ok, periodic;
    assign pins.osc_run = osc_r;

    // a reset pin level restarts the oscillator so the hold can be timed
    always_comb begin
        osc_nxt = (mode_nxt != PMRC_MODE_PDOWN) || pins.rst_level;
        phase_nxt = phase_r;
        alec_nxt = alec_r;
        if (osc_r) begin
            phase_nxt = !phase_r;
            if (alec_r == 3'(PMRC_ALE_PERIOD_OSC - 1)) begin
                alec_nxt = '0;
            end else begin
                alec_nxt = alec_r + 3'd1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            osc_r <= 1'b1;
            phase_r <= 1'b0;
            alec_r <= '0;
        end else begin
            osc_r <= osc_nxt;
            phase_r <= phase_nxt;
            alec_r <= alec_nxt;
        end
    end

    // ==================================================================
    // pin states per mode
    logic ale_r, ale_nxt, program_fetch_strobe_r, program_fetch_strobe_nxt;
    logic p0f_r, p0f_nxt, p2a_r, p2a_nxt;
    logic rst_r, rst_nxt, halt_r, halt_nxt;

    // strobe keeps toggling whenever external memory still needs it
    assign quiet_ok = !pwr_r[PMRC_BIT_QUIET] || ext_r ||
                      external_data_move || fetch_above_internal;
    assign periodic = osc_r && (alec_r < 3'(PMRC_ALE_HIGH_OSC));

    always_comb begin
        ale_nxt = 1'b1;
        program_fetch_strobe_nxt = 1'b1;
        p0f_nxt = 1'b0;
        p2a_nxt = 1'b0;
        unique case (mode_r)
            PMRC_MODE_RESET: begin
                ale_nxt = 1'b1;
            end
            PMRC_MODE_RUN: begin
                ale_nxt = periodic && quiet_ok;
                program_fetch_strobe_nxt = cpu_program_fetch_strobe_n || !ext_r;
                p0f_nxt = ext_r;
                p2a_nxt = ext_r;
            end
            PMRC_MODE_IDLE: begin
                ale_nxt = 1'b1;
                p0f_nxt = ext_r;
                p2a_nxt = ext_r;
            end
            PMRC_MODE_PDOWN: begin
                ale_nxt = 1'b0;
                program_fetch_strobe_nxt = 1'b0;
                p0f_nxt = ext_r;
            end
        endcase
        rst_nxt = (mode_nxt == PMRC_MODE_RESET);
        halt_nxt = (mode_nxt == PMRC_MODE_IDLE) ||
                   (mode_nxt == PMRC_MODE_PDOWN);
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ale_r <= 1'b1;
            program_fetch_strobe_r <= 1'b1;
            p0f_r <= 1'b0;
            p2a_r <= 1'b0;
            rst_r <= 1'b1;
            halt_r <= 1'b0;
        end else begin
            ale_r <= ale_nxt;
            program_fetch_strobe_r <= program_fetch_strobe_nxt;
            p0f_r <= p0f_nxt;
            p2a_r <= p2a_nxt;
            rst_r <= rst_nxt;
            halt_r <= halt_nxt;
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign cpu_reset = rst_r;
    assign cpu_halt = halt_r;
    assign osc_run = osc_r;
    assign clk_phase_en = phase_r;
    assign ale = ale_r;
    assign program_fetch_strobe_n = program_fetch_strobe_r;
    assign port0_float = p0f_r;
    assign port2_addr_sel = p2a_r;
    assign ext_fetch = ext_r;
    assign baud_doubler = pwr_r[PMRC_BIT_BAUD];

    // ==================================================================
    // checks
    property p_rst_hold;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(pins.rst_active) |-> $past(pins.rst_level, 20);
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("reset took hold too early");

    property p_fetch_latch;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r != PMRC_MODE_RESET && !pins.rst_active) |=> $stable(ext_r);
    endproperty
    a_fetch_latch: assert property (p_fetch_latch)
        else $error("fetch select changed outside reset");

    property p_phase;
        @(posedge ref_clk) disable iff (!nrst)
        (osc_r && $past(osc_r) && $past(nrst)) |-> (phase_r != $past(phase_r));
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase did not toggle");

    property p_idle_entry;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r == PMRC_MODE_RUN && pwr_wr && !pins.rst_active &&
         wbyte[PMRC_BIT_IDLE] && !wbyte[PMRC_BIT_PD])
        |=> (halt_r && osc_r && !rst_r);
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("idle not entered after request");

    property p_idle_wake;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r == PMRC_MODE_IDLE && irq_pending && !pins.rst_active)
        |=> (!halt_r && !pwr_r[PMRC_BIT_IDLE]);
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("interrupt did not end idle");

    property p_pd_entry;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r == PMRC_MODE_RUN && pwr_wr && wbyte[PMRC_BIT_PD] &&
         !pins.rst_active && !pins.rst_level)
        |=> (mode_r == PMRC_MODE_PDOWN && !osc_r);
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down not entered");

    property p_pd_stay;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r == PMRC_MODE_PDOWN && !pins.rst_active)
        |=> (mode_r == PMRC_MODE_PDOWN);
    endproperty
    a_pd_stay: assert property (p_pd_stay)
        else $error("power-down left without reset");

    property p_reg_reset;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(rst_r) |-> (pwr_r == PMRC_PWR_CTRL_RESET);
    endproperty
    a_reg_reset: assert property (p_reg_reset)
        else $error("register not zero after reset");

    property p_mode_pins;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r == PMRC_MODE_PDOWN) ##1 (mode_r == PMRC_MODE_PDOWN)
        |-> (!ale_r && !program_fetch_strobe_r);
    endproperty
    a_mode_pins: assert property (p_mode_pins)
        else $error("strobes not low in power-down");

    property p_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        (mode_r == PMRC_MODE_RUN && !quiet_ok) |=> !ale_r;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("strobe pulsed while quiet");

    c_idle: cover property (@(posedge ref_clk) disable iff (!nrst)
        mode_r == PMRC_MODE_IDLE ##1 mode_r == PMRC_MODE_RUN);
    c_pdown: cover property (@(posedge ref_clk) disable iff (!nrst)
        mode_r == PMRC_MODE_PDOWN ##1 mode_r == PMRC_MODE_RESET);
    c_quiet: cover property (@(posedge ref_clk) disable iff (!nrst)
        mode_r == PMRC_MODE_RUN && pwr_r[PMRC_BIT_QUIET] && !quiet_ok);

endmodule // pmrc_top

// ==== tb/pmrc_partner.sv ====
// model of the external reset circuit and the external address latch
`timescale 1ns/1ps
// ==================================================================
// reset driver and latch strobe counter
module pmrc_partner (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [7:0] hold_len,
    input wire logic ale,
    output logic rst_pin,
    output logic [15:0] latch_cnt
);
    logic [7:0] left_r = 8'h00;
    logic ale_q = 1'b0;
    logic [15:0] cnt_r = 16'h0000;

    // a request holds the pin high for hold_len whole cycles
    always @(posedge ref_clk) begin
        if (go) begin
            left_r <= hold_len;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    // released pin falls to the internal pull-down level
    assign rst_pin = go | (left_r > 8'h01);

    // the latch only sees rising strobe edges, so count those
    always @(posedge ref_clk) begin
        ale_q <= ale;
        if (ale && !ale_q) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    assign latch_cnt = cnt_r;
endmodule // pmrc_partner

// ==== tb/power_mode_reset_control_bench.sv ====
// self-checking bench for the power mode and reset control block
`timescale 1ns/1ps
module power_mode_reset_control_bench;
    import pmrc_pkg::*;
    // ==================================================================
    // stimulus and observed signals
    logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, go;
    logic [PMRC_ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic rst_pin, ext_fetch_sel_n_pin, irq_pending, external_data_move;
    logic fetch_above_internal, cpu_program_fetch_strobe_n, cpu_reset, cpu_halt, osc_run;
    logic clk_phase_en, ale, program_fetch_strobe_n, port0_float;
    logic port2_addr_sel, ext_fetch, baud_doubler;
    logic [7:0] hold_len, rd, v;
    logic [15:0] latch_cnt, c0;
    logic [31:0] seed = 32'h359fdb31;
    int num_errors = 0;
    int n_compared = 0;

    // free-running oscillator, 10 ns period
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==================================================================
    // design and far-side model
    pmrc_top #(.HOLD(24)) i_pmrc_top (.ref_clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .rst_pin, .ext_fetch_sel_n_pin,
        .irq_pending, .external_data_move, .fetch_above_internal,
        .cpu_program_fetch_strobe_n, .cpu_reset, .cpu_halt, .osc_run, .clk_phase_en, .ale,
        .program_fetch_strobe_n, .port0_float, .port2_addr_sel,
        .ext_fetch, .baud_doubler);
    pmrc_partner i_pmrc_partner (.ref_clk, .go, .hold_len, .ale,
        .rst_pin, .latch_cnt);

    // ==================================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task end_of_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one bus access; request held until waitrequest is seen low
    task bus(input logic we, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            num_errors++;
            end_of_test;
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task wr(input logic [7:0] d);
        bus(1'b1, PMRC_PWR_CTRL_ADDR, d);
    endtask

    task rdc(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, e);
    endtask

    // pulse the reset pin, then see whether an internal reset followed
    task do_reset(input logic [7:0] len, input logic expect_it);
        int n;
        n = 0;
        hold_len <= len;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        while (cpu_reset !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n < 60, expect_it);
        n = 0;
        while (cpu_reset !== 1'b0 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 60) begin
            num_errors++;
            end_of_test;
        end
        tick(3);
    endtask

    // 60 cycles hold exactly ten strobe periods whatever the phase
    task ale_cnt(input logic [15:0] e);
        tick(2); // caller's strobe setting takes two edges to reach the pin
        c0 = latch_cnt;
        tick(60);
        chk(latch_cnt - c0, e);
    endtask

    // idle, then power-down, then leave through the reset pin
    task modes(input logic e, input logic nxt);
        wr(8'h21);
        tick(2);
        chk({cpu_halt, ale, program_fetch_strobe_n, port0_float,
            port2_addr_sel}, {3'b111, e, e});
        wr(8'h2d);
        rdc(PMRC_STATUS_ADDR, {5'h00, e, 2'b01});
        rdc(PMRC_PWR_CTRL_ADDR, 8'h21);
        v = 8'(xs());
        tick(int'(v[3:0]) + 1);
        irq_pending <= 1'b1;
        tick(2);
        chk(cpu_halt, 1'b0);
        irq_pending <= 1'b0;
        rdc(PMRC_PWR_CTRL_ADDR, 8'h20);
        wr(8'h23);
        tick(2);
        chk({osc_run, cpu_halt, ale, program_fetch_strobe_n, port0_float,
            port2_addr_sel}, {4'b0100, e, 1'b0});
        rdc(PMRC_STATUS_ADDR, {5'h00, e, 2'b10});
        irq_pending <= 1'b1;
        tick(10);
        chk({cpu_halt, osc_run}, 2'b10);
        irq_pending <= 1'b0;
        ext_fetch_sel_n_pin <= ~nxt;
        do_reset(8'd40, 1'b1);
        chk(osc_run, 1'b1);
        rdc(PMRC_PWR_CTRL_ADDR, 8'h00);
        ext_fetch_sel_n_pin <= nxt;
        tick(10);
        chk(ext_fetch, nxt);
    endtask

    // ==================================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hf;
        ext_fetch_sel_n_pin = 1'b1;
        irq_pending = 1'b0;
        external_data_move = 1'b0;
        fetch_above_internal = 1'b0;
        cpu_program_fetch_strobe_n = 1'b1;
        go = 1'b0;
        hold_len = 8'h00;
        tick(5);
        nrst <= 1'b1;
        tick(2); // the release reset must be over before the pin is pulsed
        do_reset(8'd40, 1'b1);
        chk(ext_fetch, 1'b0);
        rdc(PMRC_PWR_CTRL_ADDR, 8'h00);
        rdc(10'h000, 8'h00);
        repeat (6) begin
            v = 8'(xs()) & 8'hfc;
            cpu_program_fetch_strobe_n <= v[6];
            wr(v);
            rdc(PMRC_PWR_CTRL_ADDR, v & 8'hac);
            chk(baud_doubler, v[7]);
            chk(program_fetch_strobe_n, 1'b1);
        end
        wr(8'h00);
        avs_byteenable <= 4'h0;
        wr(8'h8c);
        avs_byteenable <= 4'hf;
        rdc(PMRC_PWR_CTRL_ADDR, 8'h00);
        v[0] = clk_phase_en;
        @(posedge ref_clk);
        chk(clk_phase_en, {~v[0]});
        ale_cnt(16'd10);
        wr(8'h20);
        ale_cnt(16'd0);
        chk(ale, 1'b0);
        external_data_move <= 1'b1;
        ale_cnt(16'd10);
        external_data_move <= 1'b0;
        fetch_above_internal <= 1'b1;
        ale_cnt(16'd10);
        fetch_above_internal <= 1'b0;
        modes(1'b0, 1'b1);
        wr(8'h20);
        cpu_program_fetch_strobe_n <= 1'b0;
        ale_cnt(16'd10);
        chk(program_fetch_strobe_n, 1'b0);
        modes(1'b1, 1'b0);
        do_reset(8'd22, 1'b0);
        end_of_test;
    end
endmodule // power_mode_reset_control_bench
